// file: pkg/bcs_params.svh
// named constants for the battery charge sequencer
`ifndef BCS_PARAMS_SVH
`define BCS_PARAMS_SVH
// ****************************************************************
// clock and timer figures
// ****************************************************************
`define BCS_CLK_HZ 64'd250000000
`define BCS_HOUR_S 64'd3600
`define BCS_RT_REF_KOHM 64'd154
`define BCS_NTC_SAMPLE_MS 64'd1
`define BCS_MS_PER_S 64'd1000
`define BCS_QTRS_PER_PERIOD 64'd4
// ****************************************************************
// widths and quarter counts
// ****************************************************************
`define BCS_KOHM_W 16
`define BCS_QTR_W 18
`define BCS_PRE_W 32
`define BCS_LOWCELL_QTRS 3'h1
`define BCS_RELOAD_QTRS 3'h3
`define BCS_TOTAL_QTRS 3'h4
`endif

// file: pkg/bcs_pkg.sv
// types shared by the battery charge sequencer
package bcs_pkg;
  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    BCS_SLEEP,
    BCS_SHUTDOWN,
    BCS_CONDITION,
    BCS_CHARGE,
    BCS_DONE,
    BCS_FAULT
  } bcs_state_t;

  // float target, index is {cell count, chemistry}
  typedef enum logic [1:0] {
    BCS_FLOAT_12V3,
    BCS_FLOAT_12V6,
    BCS_FLOAT_16V4,
    BCS_FLOAT_16V8
  } bcs_float_t;

  // ****************************************************************
  // comparator results from the analogue front end
  // ****************************************************************
  typedef struct packed {
    logic supply_above_battery;
    logic supply_above_undervoltage_lockout;
    logic supply_above_ref;
    logic supply_above_ref_hyst;
    logic low_cell;
    logic taper_current;
    logic input_limiting;
    logic thermistor_ok;
    logic timer_defeat;
  } bcs_sense_t;

  // ****************************************************************
  // indicator pins, active low ones end in _n
  // ****************************************************************
  typedef struct packed {
    logic charge_status_oe;
    logic low_cell_indicator_n;
    logic fault_n;
    logic taper_flag_n;
    logic input_limit_indicator_n;
    logic adapter_present;
  } bcs_ind_t;
endpackage : bcs_pkg

// file: verilog/bcs_charge_timer.sv
// charge timer counting quarters of the resistor-set period
`timescale 1ns/10ps
`include "bcs_params.svh"
module bcs_charge_timer #(
  parameter longint unsigned QUARTER_CYCLES = 64'd1461038961
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic clear_in,
  input wire logic run_in,
  input wire logic reload_in,
  input wire logic [`BCS_KOHM_W-1:0] kohm_in,
  output logic lowcell_due_out,
  output logic expired_out
);
  import bcs_pkg::*;

  localparam logic [`BCS_PRE_W-1:0] PRE_LAST = `BCS_PRE_W'(QUARTER_CYCLES - 64'd1);

  // one quarter unit is an hour over 616, so the period is kohm_in quarters times four
  function automatic logic [`BCS_QTR_W-1:0] qtrs(input logic [`BCS_KOHM_W-1:0] k,
                                                 input logic [2:0] n);
    logic [2*`BCS_QTR_W-1:0] p;
    p = {2'h0, k, 15'h0000, 3'h0} * 36'h0;
    p = {20'h00000, k} * {33'h000000000, n};
    return p[`BCS_QTR_W-1:0];
  endfunction : qtrs

  logic [`BCS_PRE_W-1:0] pre_q, pre_d;
  logic [`BCS_QTR_W-1:0] elapsed_q, elapsed_d;
  logic lowcell_due_d, expired_d;

  // ****************************************************************
  // next values
  // ****************************************************************
  always_comb begin
    pre_d = pre_q;
    elapsed_d = elapsed_q;
    if (clear_in) begin
      pre_d = '0;
      elapsed_d = '0;
    end else if (reload_in) begin
      elapsed_d = qtrs(kohm_in, `BCS_RELOAD_QTRS);
    end else if (run_in && !expired_out) begin
      if (pre_q == PRE_LAST) begin
        pre_d = '0;
        elapsed_d = elapsed_q + `BCS_QTR_W'(1);
      end else begin
        pre_d = pre_q + `BCS_PRE_W'(1);
      end
    end
    lowcell_due_d = !clear_in && (elapsed_q >= qtrs(kohm_in, `BCS_LOWCELL_QTRS));
    expired_d = !clear_in && (elapsed_q >= qtrs(kohm_in, `BCS_TOTAL_QTRS));
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pre_q <= '0;
      elapsed_q <= '0;
      lowcell_due_out <= 1'b0;
      expired_out <= 1'b0;
    end else begin
      pre_q <= pre_d;
      elapsed_q <= elapsed_d;
      lowcell_due_out <= lowcell_due_d;
      expired_out <= expired_d;
    end
  end
endmodule : bcs_charge_timer

// file: verilog/bcs_charge_sequencer.sv
// charge sequencer: decides when the charger runs, pauses or ends
`timescale 1ns/10ps
`include "bcs_params.svh"
module bcs_charge_sequencer #(
  parameter longint unsigned QUARTER_CYCLES =
    (`BCS_HOUR_S * `BCS_CLK_HZ) / (`BCS_RT_REF_KOHM * `BCS_QTRS_PER_PERIOD),
  parameter longint unsigned NTC_SAMPLE_CYCLES =
    (`BCS_NTC_SAMPLE_MS * `BCS_CLK_HZ) / `BCS_MS_PER_S
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire bcs_pkg::bcs_sense_t sense_in,
  input wire logic charger_halt_input_in,
  input wire logic cell_count_select_in,
  input wire logic cell_chemistry_select_in,
  input wire logic [`BCS_KOHM_W-1:0] timer_resistor_kohm_in,
  output bcs_pkg::bcs_ind_t indicators_out,
  output logic charge_status_out,
  output logic charge_enable_out,
  output logic sleep_out,
  output logic low_cell_threshold_sel_out,
  output bcs_pkg::bcs_float_t float_target_out,
  output bcs_pkg::bcs_state_t state_out
);
  import bcs_pkg::*;

  localparam logic [`BCS_PRE_W-1:0] NTC_LAST = `BCS_PRE_W'(NTC_SAMPLE_CYCLES - 64'd1);

  // ****************************************************************
  // adapter qualification
  // ****************************************************************
  // the hysteresis keeps a sagging adapter from chattering the charger on and off
  logic adapter_ok_q, adapter_ok_d;

  always_comb begin
    adapter_ok_d = adapter_ok_q;
    if (!sense_in.supply_above_battery || !sense_in.supply_above_ref) begin
      adapter_ok_d = 1'b0;
    end else if (sense_in.supply_above_ref_hyst) begin
      adapter_ok_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      adapter_ok_q <= 1'b0;
    end else begin
      adapter_ok_q <= adapter_ok_d;
    end
  end

  // ****************************************************************
  // thermistor sampling
  // ****************************************************************
  logic [`BCS_PRE_W-1:0] ntc_cnt_q, ntc_cnt_d;
  logic ntc_ok_q, ntc_ok_d;

  always_comb begin
    ntc_cnt_d = ntc_cnt_q + `BCS_PRE_W'(1);
    ntc_ok_d = ntc_ok_q;
    if (ntc_cnt_q == NTC_LAST) begin
      ntc_cnt_d = '0;
      ntc_ok_d = sense_in.thermistor_ok;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ntc_cnt_q <= '0;
      ntc_ok_q <= 1'b1;
    end else begin
      ntc_cnt_q <= ntc_cnt_d;
      ntc_ok_q <= ntc_ok_d;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  bcs_state_t state_q, state_d;
  logic taper_q, taper_d;
  logic supply_good;
  logic running;
  logic timer_clear;
  logic timer_reload;
  logic lowcell_due;
  logic expired;

  // halt and resistor checks come in here, so an absent resistor never starts a cycle
  assign supply_good = sense_in.supply_above_battery && sense_in.supply_above_undervoltage_lockout
                       && adapter_ok_q && !charger_halt_input_in
                       && (timer_resistor_kohm_in != '0);
  assign running = (state_q == BCS_CONDITION || state_q == BCS_CHARGE) && ntc_ok_q;

  always_comb begin
    state_d = state_q;
    taper_d = taper_q;
    if (!sense_in.supply_above_battery) begin
      state_d = BCS_SLEEP;
    end else if (!supply_good) begin
      state_d = BCS_SHUTDOWN;
    end else begin
      case (state_q)
        BCS_SLEEP, BCS_SHUTDOWN: begin
          state_d = sense_in.low_cell ? BCS_CONDITION : BCS_CHARGE;
        end
        BCS_CONDITION: begin
          if (lowcell_due && !sense_in.timer_defeat) begin
            state_d = BCS_FAULT;
          end else if (!sense_in.low_cell) begin
            state_d = BCS_CHARGE;
          end
        end
        BCS_CHARGE: begin
          if (expired && !sense_in.timer_defeat) begin
            state_d = BCS_DONE;
          end
        end
        BCS_DONE, BCS_FAULT: begin
          state_d = state_q;
        end
        default: begin
          state_d = BCS_SHUTDOWN;
        end
      endcase
    end
    if (state_d == BCS_SLEEP || state_d == BCS_SHUTDOWN) begin
      taper_d = 1'b0;
    end else if (state_q == BCS_CHARGE && running && sense_in.taper_current
                 && !sense_in.input_limiting) begin
      taper_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_q <= BCS_SLEEP;
      taper_q <= 1'b0;
    end else begin
      state_q <= state_d;
      taper_q <= taper_d;
    end
  end

  // ****************************************************************
  // charge timer
  // ****************************************************************
  assign timer_clear = (state_q == BCS_SLEEP || state_q == BCS_SHUTDOWN);
  assign timer_reload = taper_d && !taper_q;

  bcs_charge_timer #(
    .QUARTER_CYCLES(QUARTER_CYCLES)
  ) u_timer (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(timer_clear),
    .run_in(running),
    .reload_in(timer_reload),
    .kohm_in(timer_resistor_kohm_in),
    .lowcell_due_out(lowcell_due),
    .expired_out(expired)
  );

  // ****************************************************************
  // indicator pins and outputs
  // ****************************************************************
  bcs_ind_t ind_d;
  logic charge_enable_d;
  logic sleep_d;
  logic active;

  always_comb begin
    active = (state_d == BCS_CONDITION || state_d == BCS_CHARGE);
    charge_enable_d = active && ntc_ok_d;
    sleep_d = (state_d == BCS_SLEEP);
    ind_d.charge_status_oe = active;
    ind_d.low_cell_indicator_n = !(sense_in.low_cell && state_d != BCS_SLEEP
                                   && state_d != BCS_SHUTDOWN);
    ind_d.fault_n = !(state_d == BCS_FAULT || (active && !ntc_ok_d));
    ind_d.taper_flag_n = !taper_d;
    ind_d.input_limit_indicator_n = !(sense_in.input_limiting && charge_enable_d);
    ind_d.adapter_present = sense_in.supply_above_battery && adapter_ok_d;
  end

  // the status pin only ever sinks, so its data bit is a constant low
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      indicators_out <= '{charge_status_oe: 1'b0, low_cell_indicator_n: 1'b1,
                          fault_n: 1'b1, taper_flag_n: 1'b1,
                          input_limit_indicator_n: 1'b1, adapter_present: 1'b0};
      charge_status_out <= 1'b0;
      charge_enable_out <= 1'b0;
      sleep_out <= 1'b1;
      low_cell_threshold_sel_out <= 1'b1;
      float_target_out <= BCS_FLOAT_16V8;
      state_out <= BCS_SLEEP;
    end else begin
      indicators_out <= ind_d;
      charge_status_out <= 1'b0;
      charge_enable_out <= charge_enable_d;
      sleep_out <= sleep_d;
      low_cell_threshold_sel_out <= cell_chemistry_select_in;
      float_target_out <= bcs_float_t'({cell_count_select_in,
                                        cell_chemistry_select_in});
      state_out <= state_d;
    end
  end
endmodule : bcs_charge_sequencer

// file: tb/bcs_assertions.sv
// checker for the battery charge sequencer ports
`timescale 1ns/10ps
`include "bcs_params.svh"
module bcs_checker (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire bcs_pkg::bcs_sense_t sense_in,
  input wire logic charger_halt_input_in,
  input wire logic cell_count_select_in,
  input wire logic cell_chemistry_select_in,
  input wire logic [`BCS_KOHM_W-1:0] timer_resistor_kohm_in,
  input wire bcs_pkg::bcs_ind_t indicators_out,
  input wire logic charge_enable_out,
  input wire logic low_cell_threshold_sel_out,
  input wire bcs_pkg::bcs_float_t float_target_out,
  input wire bcs_pkg::bcs_state_t state_out
);
  import bcs_pkg::*;
  // ****
  // port relations
  // ****
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  property p_halt; charger_halt_input_in |-> ##[1:2] !charge_enable_out; endproperty
  a_halt: assert property (p_halt) else $error("charger runs while halted");
  property p_run_cause;
    charge_enable_out |-> $past(!charger_halt_input_in && timer_resistor_kohm_in != 0);
  endproperty
  a_run_cause: assert property (p_run_cause) else $error("charger runs without cause");
  property p_adapter;
    !sense_in.supply_above_battery |-> ##[1:2] !indicators_out.adapter_present;
  endproperty
  a_adapter: assert property (p_adapter) else $error("adapter shown with low supply");
  property p_limit;
    !indicators_out.input_limit_indicator_n |-> $past(sense_in.input_limiting);
  endproperty
  a_limit: assert property (p_limit) else $error("limit shown without limiting");
  property p_float;
    !$past(sys_rst_in) |->
      float_target_out == $past({cell_count_select_in, cell_chemistry_select_in});
  endproperty
  a_float: assert property (p_float) else $error("float target wrong");
  property p_thr;
    !$past(sys_rst_in) |-> low_cell_threshold_sel_out == $past(cell_chemistry_select_in);
  endproperty
  a_thr: assert property (p_thr) else $error("low cell threshold wrong");
  property p_fault;
    state_out == BCS_FAULT && $past(state_out) == BCS_FAULT |->
      !indicators_out.fault_n && !indicators_out.charge_status_oe;
  endproperty
  a_fault: assert property (p_fault) else $error("fault state pins wrong");
  property p_done;
    state_out == BCS_DONE && $past(state_out) == BCS_DONE |->
      !indicators_out.charge_status_oe && !charge_enable_out;
  endproperty
  a_done: assert property (p_done) else $error("charge goes on after timeout");
  property p_taper_hold;
    $past(!indicators_out.taper_flag_n) && !(state_out inside {BCS_SLEEP, BCS_SHUTDOWN})
      && !($past(state_out) inside {BCS_SLEEP, BCS_SHUTDOWN}) |-> !indicators_out.taper_flag_n;
  endproperty
  a_taper_hold: assert property (p_taper_hold) else $error("taper latch dropped");
  property p_taper_cause;
    $fell(indicators_out.taper_flag_n) |->
      $past(sense_in.taper_current && !sense_in.input_limiting);
  endproperty
  a_taper_cause: assert property (p_taper_cause) else $error("taper flag set wrongly");
endmodule : bcs_checker
bind bcs_charge_sequencer bcs_checker chk_u (.clk_sys_in, .sys_rst_in, .sense_in,
  .charger_halt_input_in, .cell_count_select_in, .cell_chemistry_select_in,
  .timer_resistor_kohm_in, .indicators_out, .charge_enable_out, .low_cell_threshold_sel_out,
  .float_target_out, .state_out);

// file: tb/bcs_far_side.sv
// far side model: adapter, battery cell and thermistor
`timescale 1ns/10ps
module bcs_far_side (
  input wire logic clk_sys_in,
  input wire logic charge_enable_in,
  input wire logic supply_on_in,
  input wire logic stuck_in,
  input wire logic fresh_in,
  input wire logic hot_in,
  input wire logic defeat_in,
  input wire logic limit_in,
  output bcs_pkg::bcs_sense_t sense_out
);
  import bcs_pkg::*;
  // ****
  // cell voltage rises one step a cycle while charged and not stuck
  // ****
  int volt = 0;
  always @(negedge clk_sys_in) begin
    if (fresh_in) begin
      volt <= 0;
    end else if (charge_enable_in && !stuck_in) begin
      volt <= volt + 1;
    end
  end
  // limiting also lowers the current, so the taper comparator fires then too
  assign sense_out = '{supply_on_in, supply_on_in, supply_on_in, supply_on_in, volt < 10,
    volt >= 30 || limit_in, limit_in, !hot_in, defeat_in};
endmodule : bcs_far_side

// file: tb/tb_top.sv
// self-checking bench for the battery charge sequencer
`timescale 1ns/10ps
module tb_top;
  import bcs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, halt = 1'b0, cnt = 1'b1, cell_chemistry_select = 1'b1;
  logic sup = 1'b0, stuck = 1'b0, fresh = 1'b0, hot = 1'b0, dfe = 1'b0, lim = 1'b0;
  logic en, slp, thr, csd;
  logic [15:0] kohm = 16'h0003;
  bcs_sense_t sense;
  bcs_ind_t ind;
  bcs_float_t flt;
  bcs_state_t st;
  int fail_count = 0, n_checks = 0, n = 0;
  // ****
  // clock, design and far side
  // ****
  initial begin
    forever #2 clk = ~clk;
  end
  // short quarter keeps the whole charge period at 48 cycles with 3 kohm
  bcs_charge_sequencer #(.QUARTER_CYCLES(64'd4), .NTC_SAMPLE_CYCLES(64'd2)) dut_u (
    .clk_sys_in(clk), .sys_rst_in(rst), .sense_in(sense), .charger_halt_input_in(halt),
    .cell_count_select_in(cnt), .cell_chemistry_select_in(cell_chemistry_select),
    .timer_resistor_kohm_in(kohm), .indicators_out(ind), .charge_status_out(csd),
    .charge_enable_out(en), .sleep_out(slp), .low_cell_threshold_sel_out(thr),
    .float_target_out(flt), .state_out(st));
  bcs_far_side far_u (.clk_sys_in(clk), .charge_enable_in(en), .supply_on_in(sup),
    .stuck_in(stuck), .fresh_in(fresh), .hot_in(hot), .defeat_in(dfe), .limit_in(lim),
    .sense_out(sense));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic wait_st(input bcs_state_t s, input int lim_c);
    n = 0;
    while (st !== s && n < lim_c) begin
      @(negedge clk);
      n++;
    end
    chk(st, s);
  endtask : wait_st
  task automatic pulse_halt();
    halt = 1'b1;
    cyc(3);
    chk({st, en}, {BCS_SHUTDOWN, 1'b0});
    cyc(22);
    halt = 1'b0;
  endtask : pulse_halt
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    #8000;
    fail_count++;
    stop_test();
  end
  initial begin
    n = $urandom(32'he307);
    cyc(10);
    rst = 1'b0;
    chk({st, slp, en, csd, ind}, {BCS_SLEEP, 3'b100, 6'b011110});
    $display("test reset done");
    repeat (16) begin
      {cnt, cell_chemistry_select} = 2'($urandom);
      cyc(2);
      chk(flt, {cnt, cell_chemistry_select});
      chk(thr, cell_chemistry_select);
    end
    $display("test selects done");
    stuck = 1'b1;
    kohm = 16'h0000;
    sup = 1'b1;
    cyc(6);
    chk({st, en, ind.charge_status_oe}, {BCS_SHUTDOWN, 2'b00});
    kohm = 16'h0003;
    wait_st(BCS_CONDITION, 8);
    chk({ind.charge_status_oe, ind.low_cell_indicator_n, en}, 3'b101);
    wait_st(BCS_FAULT, 30);
    chk(n >= 11 && n <= 16, 1);
    cyc(2);
    chk({ind.fault_n, ind.charge_status_oe, en}, 3'b000);
    pulse_halt();
    wait_st(BCS_CONDITION, 8);
    $display("test low cell done");
    dfe = 1'b1;
    pulse_halt();
    cyc(40);
    chk(st, BCS_CONDITION);
    sup = 1'b0;
    cyc(4);
    chk({st, slp, ind.adapter_present}, {BCS_SLEEP, 2'b10});
    $display("test defeat done");
    dfe = 1'b0;
    stuck = 1'b0;
    fresh = 1'b1;
    cyc(1);
    fresh = 1'b0;
    sup = 1'b1;
    wait_st(BCS_CHARGE, 30);
    hot = 1'b1;
    cyc(6);
    chk({en, ind.fault_n, ind.charge_status_oe}, 3'b001);
    hot = 1'b0;
    cyc(6);
    chk({en, ind.fault_n}, 2'b11);
    lim = 1'b1;
    cyc(4);
    chk(ind.input_limit_indicator_n, 0);
    chk(ind.taper_flag_n, 1);
    lim = 1'b0;
    n = 0;
    while (ind.taper_flag_n !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(ind.taper_flag_n, 0);
    wait_st(BCS_DONE, 40);
    chk(n >= 11 && n <= 16, 1);
    chk({en, ind.charge_status_oe, ind.taper_flag_n}, 0);
    pulse_halt();
    chk(ind.taper_flag_n, 1);
    $display("test charge done");
    stop_test();
  end
endmodule : tb_top
